//--- hw/dtf_trip_manager.sv
// Trip latch, reset gating, fault history and register slave of the drive fault manager
`timescale 1ns/1ps

module dtf_trip_manager #(
  parameter int unsigned RESET_HOLD_CYCLES = dtf_pkg::RESET_HOLD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register bus
  input wire dtf_pkg::dtf_axi_req_s axi_req_i,
  output dtf_pkg::dtf_axi_rsp_s axi_rsp_o,
  // Asynchronous sensor and terminal pins
  input wire dtf_pkg::dtf_pins_s pins_i,
  // Same-clock inputs from control and program engine
  input wire logic brake_release_i,
  input wire logic release_current_req_i,
  input wire logic release_current_ok_i,
  input wire logic [15:0] speed_i,
  input wire logic [31:0] position_i,
  input wire logic [3:0] nest_depth_i,
  input wire logic user_trip_i,
  input wire logic [3:0] user_trip_index_i,
  input wire logic option_fault_i,
  input wire logic [3:0] option_fault_index_i,
  // Trip state outputs
  output logic power_enable_o,
  output logic tripped_o,
  output logic [7:0] trip_code_o,
  output logic undervolt_wait_o,
  output logic reset_blocked_o
);

  localparam int NPIN = $bits(dtf_pkg::dtf_pins_s);

  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic term_prev;
    logic key_prev;
    logic tripped;
    logic [7:0] code;
    logic power_only;
    logic [31:0] hold_cnt;
    logic [dtf_pkg::HIST_DEPTH-1:0][7:0] hist;
    logic power_en;
    logic uv_wait;
    logic brk_prev;
    logic brk_wait;
    logic [31:0] brk_cnt;
    logic [31:0] rel_cnt;
    logic [4:0] ctrl;
    logic [31:0] conf_wait;
    logic [31:0] rel_wait;
    logic [15:0] max_freq;
    logic [7:0] ovs_level;
    logic [31:0] pos_min;
    logic [31:0] pos_max;
    logic aw_v;
    logic [7:0] aw_addr;
    logic w_v;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtf_state_s;

  dtf_state_s s_q;
  dtf_state_s s_d;
  dtf_pkg::dtf_pins_s pin;
  logic [dtf_pkg::NFAULT-1:0] fault;
  logic [dtf_pkg::NFAULT-1:0][7:0] fcode;
  logic [7:0] first_code;
  logic term_edge;
  logic key_edge;
  logic reset_ok;
  logic brake_fault;
  logic overspeed;
  logic pos_out;

  // Byte-lane merge of a register write
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Synchronised pins, read only from the second stage
  assign pin = dtf_pkg::dtf_pins_s'(s_q.sync2);
  assign term_edge = pin.reset_terminal_input && !s_q.term_prev;
  assign key_edge = pin.keypad_reset && !s_q.key_prev;

  // Speed limit compare in percent of maximum frequency
  assign overspeed = (32'(speed_i) * dtf_pkg::OVS_SCALE) >= 
                     (32'(s_q.max_freq) * 32'(s_q.ovs_level));
  assign pos_out = ($signed(position_i) < $signed(s_q.pos_min)) ||
                   ($signed(position_i) > $signed(s_q.pos_max));
  assign brake_fault = s_q.ctrl[dtf_pkg::CTRL_BRAKE_BIT] &&
                       ((s_q.brk_wait && !pin.brake_confirm && s_q.brk_cnt >= s_q.conf_wait) ||
                        (s_q.rel_cnt >= s_q.rel_wait && release_current_req_i &&
                         !release_current_ok_i));

  // Fault requests in priority order, index zero highest
  always_comb begin
    fault = '0;
    fcode = '0;
    fault[0] = pin.overcurrent;
    fcode[0] = dtf_pkg::CODE_DRIVER;
    fault[1] = pin.memory_fault;
    fcode[1] = dtf_pkg::CODE_MEMORY;
    fault[2] = pin.ground_fault;
    fcode[2] = dtf_pkg::CODE_GROUND;
    fault[3] = pin.over_temp;
    fcode[3] = dtf_pkg::CODE_THERMAL;
    fault[4] = pin.mains_unrecognised;
    fcode[4] = dtf_pkg::CODE_MAINS;
    fault[5] = pin.cpu_link_lost;
    fcode[5] = dtf_pkg::CODE_CPU_LINK;
    fault[6] = pin.safe_stop;
    fcode[6] = dtf_pkg::CODE_SAFE_STOP;
    fault[7] = pin.thermistor_hot && s_q.ctrl[dtf_pkg::CTRL_THERM_BIT];
    fcode[7] = dtf_pkg::CODE_THERMISTOR;
    fault[8] = pin.encoder_fault;
    fcode[8] = dtf_pkg::CODE_ENCODER;
    fault[9] = overspeed;
    fcode[9] = dtf_pkg::CODE_OVERSPEED;
    fault[10] = pos_out;
    fcode[10] = dtf_pkg::CODE_POSITION;
    fault[11] = pin.low_speed_overload;
    fcode[11] = dtf_pkg::CODE_LOW_SPEED;
    fault[12] = brake_fault;
    fcode[12] = dtf_pkg::CODE_BRAKE;
    fault[13] = pin.keypad_link_lost;
    fcode[13] = dtf_pkg::CODE_KEYPAD;
    fault[14] = pin.serial_timeout &&
                (s_q.ctrl[dtf_pkg::CTRL_COMM_LSB +: 2] == dtf_pkg::COMM_ACT_TRIP);
    fcode[14] = dtf_pkg::CODE_SERIAL;
    fault[15] = pin.prg_corrupt ||
                (pin.program_run_terminal && !s_q.ctrl[dtf_pkg::CTRL_PRG_BIT]);
    fcode[15] = dtf_pkg::CODE_PRG_INVALID;
    fault[16] = nest_depth_i > dtf_pkg::NEST_LIMIT;
    fcode[16] = dtf_pkg::CODE_PRG_NEST;
    fault[17] = pin.prg_unexecutable;
    fcode[17] = dtf_pkg::CODE_PRG_INSTR;
    fault[18] = user_trip_i && (user_trip_index_i <= dtf_pkg::INDEX_MAX);
    fcode[18] = {dtf_pkg::CODE_USER_TENS, user_trip_index_i};
    fault[19] = option_fault_i && (option_fault_index_i <= dtf_pkg::INDEX_MAX);
    fcode[19] = {dtf_pkg::CODE_OPTION_TENS, option_fault_index_i};
  end

  // Pick the highest-priority request of this cycle
  always_comb begin
    first_code = dtf_pkg::CODE_NONE;
    for (int i = dtf_pkg::NFAULT - 1; i >= 0; i--) begin
      if (fault[i]) begin
        first_code = fcode[i];
      end
    end
  end

  // Reset permitted only after hold-off, never for power-cycle trips
  assign reset_ok = s_q.tripped && (s_q.hold_cnt == 32'h0) && !s_q.power_only &&
                    (term_edge || (key_edge && s_q.code != dtf_pkg::CODE_SAFE_STOP));

  // Next state of the whole block
  always_comb begin
    logic [7:0] ra;
    logic [7:0] wa;
    s_d = s_q;
    ra = {axi_req_i.araddr[7:2], 2'b00};
    wa = {s_q.aw_addr[7:2], 2'b00};
    s_d.sync1 = pins_i;
    s_d.sync2 = s_q.sync1;
    s_d.term_prev = pin.reset_terminal_input;
    s_d.key_prev = pin.keypad_reset;

    // Brake confirmation and release-current timers
    s_d.brk_prev = brake_release_i;
    if (brake_release_i && !s_q.brk_prev) begin
      s_d.brk_wait = 1'b1;
      s_d.brk_cnt = 32'h0;
    end else if (s_q.brk_wait && (pin.brake_confirm || brake_fault)) begin
      s_d.brk_wait = 1'b0;
    end else if (s_q.brk_wait) begin
      s_d.brk_cnt = s_q.brk_cnt + 32'h1;
    end
    if (release_current_req_i && !release_current_ok_i && !brake_fault) begin
      s_d.rel_cnt = s_q.rel_cnt + 32'h1;
    end else begin
      s_d.rel_cnt = 32'h0;
    end

    // Hold-off countdown, then clear, then a new trip wins over the clear
    if (s_q.hold_cnt != 32'h0) begin
      s_d.hold_cnt = s_q.hold_cnt - 32'h1;
    end
    if (reset_ok) begin
      s_d.tripped = 1'b0;
      s_d.code = dtf_pkg::CODE_NONE;
    end
    if (!s_d.tripped && (fault != '0)) begin
      s_d.tripped = 1'b1;
      s_d.code = first_code;
      s_d.hold_cnt = RESET_HOLD_CYCLES;
      s_d.power_only = (first_code == dtf_pkg::CODE_MEMORY) ||
                       (first_code == dtf_pkg::CODE_GROUND) ||
                       (first_code == dtf_pkg::CODE_DRIVER);
      s_d.hist = {s_q.hist[dtf_pkg::HIST_DEPTH-2:0], first_code};
    end
    s_d.uv_wait = pin.undervoltage;
    s_d.power_en = !s_d.tripped && !pin.undervoltage;

    // Write channel capture and execution
    if (axi_req_i.awvalid && !s_q.aw_v) begin
      s_d.aw_v = 1'b1;
      s_d.aw_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && !s_q.w_v) begin
      s_d.w_v = 1'b1;
      s_d.w_data = axi_req_i.wdata;
      s_d.w_strb = axi_req_i.wstrb;
    end
    if (s_q.bvalid && axi_req_i.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_v && s_q.w_v && !s_q.bvalid) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = dtf_pkg::RESP_OKAY;
      unique case (wa)
        dtf_pkg::ADDR_CTRL: s_d.ctrl = 5'(wmerge(32'(s_q.ctrl), s_q.w_data, s_q.w_strb));
        dtf_pkg::ADDR_CONF_WAIT: s_d.conf_wait = wmerge(s_q.conf_wait, s_q.w_data, s_q.w_strb);
        dtf_pkg::ADDR_REL_WAIT: s_d.rel_wait = wmerge(s_q.rel_wait, s_q.w_data, s_q.w_strb);
        dtf_pkg::ADDR_MAX_FREQ: begin
          s_d.max_freq = 16'(wmerge(32'(s_q.max_freq), s_q.w_data, s_q.w_strb));
        end
        dtf_pkg::ADDR_OVS_LEVEL: begin
          s_d.ovs_level = 8'(wmerge(32'(s_q.ovs_level), s_q.w_data, s_q.w_strb));
        end
        dtf_pkg::ADDR_POS_MIN: s_d.pos_min = wmerge(s_q.pos_min, s_q.w_data, s_q.w_strb);
        dtf_pkg::ADDR_POS_MAX: s_d.pos_max = wmerge(s_q.pos_max, s_q.w_data, s_q.w_strb);
        dtf_pkg::ADDR_STATUS: s_d.bresp = dtf_pkg::RESP_OKAY; // Read-only, write dropped
        default: begin
          if (wa < dtf_pkg::ADDR_HIST0 || wa > dtf_pkg::ADDR_HIST5) begin
            s_d.bresp = dtf_pkg::RESP_SLVERR;
          end
        end
      endcase
    end

    // Read channel, answered one cycle after the address is taken
    if (s_q.rvalid && axi_req_i.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = dtf_pkg::RESP_OKAY;
      s_d.rdata = 32'h0;
      unique case (ra)
        dtf_pkg::ADDR_CTRL: s_d.rdata = 32'(s_q.ctrl);
        dtf_pkg::ADDR_CONF_WAIT: s_d.rdata = s_q.conf_wait;
        dtf_pkg::ADDR_REL_WAIT: s_d.rdata = s_q.rel_wait;
        dtf_pkg::ADDR_MAX_FREQ: s_d.rdata = 32'(s_q.max_freq);
        dtf_pkg::ADDR_OVS_LEVEL: s_d.rdata = 32'(s_q.ovs_level);
        dtf_pkg::ADDR_POS_MIN: s_d.rdata = s_q.pos_min;
        dtf_pkg::ADDR_POS_MAX: s_d.rdata = s_q.pos_max;
        dtf_pkg::ADDR_STATUS: begin
          s_d.rdata[7:0] = s_q.code;
          s_d.rdata[dtf_pkg::STAT_TRIP_BIT] = s_q.tripped;
          s_d.rdata[dtf_pkg::STAT_HOLD_BIT] = s_q.hold_cnt != 32'h0;
          s_d.rdata[dtf_pkg::STAT_UV_BIT] = s_q.uv_wait;
          s_d.rdata[dtf_pkg::STAT_PWRCYC_BIT] = s_q.power_only;
        end
        default: begin
          if (ra >= dtf_pkg::ADDR_HIST0 && ra <= dtf_pkg::ADDR_HIST5) begin
            s_d.rdata = 32'(s_q.hist[3'(ra[4:2] - 3'h0) ^ 3'h0]);
          end else begin
            s_d.rresp = dtf_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.code <= dtf_pkg::CODE_NONE;
      s_q.ctrl <= dtf_pkg::CTRL_RESET;
      s_q.conf_wait <= dtf_pkg::WAIT_RESET;
      s_q.rel_wait <= dtf_pkg::WAIT_RESET;
      s_q.max_freq <= dtf_pkg::MAX_FREQ_RESET;
      s_q.ovs_level <= dtf_pkg::OVS_LEVEL_RESET;
      s_q.pos_min <= dtf_pkg::POS_MIN_RESET;
      s_q.pos_max <= dtf_pkg::POS_MAX_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign power_enable_o = s_q.power_en;
  assign tripped_o = s_q.tripped;
  assign trip_code_o = s_q.code;
  assign undervolt_wait_o = s_q.uv_wait;
  assign reset_blocked_o = s_q.tripped && (s_q.hold_cnt != 32'h0);
  assign axi_rsp_o.awready = !s_q.aw_v;
  assign axi_rsp_o.wready = !s_q.w_v;
  assign axi_rsp_o.bvalid = s_q.bvalid;
  assign axi_rsp_o.bresp = s_q.bresp;
  assign axi_rsp_o.arready = !s_q.rvalid;
  assign axi_rsp_o.rvalid = s_q.rvalid;
  assign axi_rsp_o.rdata = s_q.rdata;
  assign axi_rsp_o.rresp = s_q.rresp;

  // Checks on trip behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_output_off;
    tripped_o |-> !power_enable_o;
  endproperty
  a_output_off: assert property (p_output_off) else $error("Power on while tripped");
  property p_hold_refuse;
    s_q.tripped && s_q.hold_cnt != 32'h0 |=> s_q.tripped;
  endproperty
  a_hold_refuse: assert property (p_hold_refuse) else $error("Reset taken in hold-off");
  property p_safe_key;
    s_q.tripped && s_q.code == dtf_pkg::CODE_SAFE_STOP && !term_edge |=> s_q.tripped;
  endproperty
  a_safe_key: assert property (p_safe_key) else $error("Safe stop left by wrong reset");
  property p_power_cycle;
    s_q.tripped && s_q.power_only |=> s_q.tripped && $stable(s_q.code);
  endproperty
  a_power_cycle: assert property (p_power_cycle) else $error("Power-cycle trip cleared");
  property p_overcurrent;
    !s_q.tripped && pin.overcurrent |=> s_q.tripped && s_q.code == dtf_pkg::CODE_DRIVER;
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("Overcurrent not tripped");
  property p_history;
    $rose(s_q.tripped) |-> s_q.hist[0] == s_q.code && s_q.hist[1] == $past(s_q.hist[0]);
  endproperty
  a_history: assert property (p_history) else $error("History not shifted");
  property p_undervolt;
    pin.undervoltage |=> undervolt_wait_o && !power_enable_o;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("Undervoltage not held");
  property p_code_latched;
    s_q.tripped && !reset_ok |=> s_q.tripped && $stable(s_q.code);
  endproperty
  a_code_latched: assert property (p_code_latched) else $error("Trip code changed");
  property p_hold_load;
    $rose(s_q.tripped) |-> s_q.hold_cnt == RESET_HOLD_CYCLES;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("Hold-off not loaded");

  c_trip: cover property ($rose(tripped_o));
  c_clear: cover property (reset_ok ##1 !tripped_o);
  c_user: cover property (tripped_o && trip_code_o[7:4] == dtf_pkg::CODE_USER_TENS);
  c_brake: cover property (brake_fault && !s_q.tripped);

endmodule

//--- hw/dtf_pkg.sv
// Constants, codes, register map and carrier types of the drive trip fault manager
package dtf_pkg;

  // Clock and reset hold-off timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RESET_HOLD_S = 10;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_S * CLK_HZ;

  // Trip codes, shown as two decimal digits (BCD)
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_MEMORY = 8'h08;
  localparam logic [7:0] CODE_GROUND = 8'h14;
  localparam logic [7:0] CODE_THERMAL = 8'h21;
  localparam logic [7:0] CODE_CPU_LINK = 8'h22;
  localparam logic [7:0] CODE_MAINS = 8'h25;
  localparam logic [7:0] CODE_DRIVER = 8'h30;
  localparam logic [7:0] CODE_THERMISTOR = 8'h35;
  localparam logic [7:0] CODE_BRAKE = 8'h36;
  localparam logic [7:0] CODE_SAFE_STOP = 8'h37;
  localparam logic [7:0] CODE_LOW_SPEED = 8'h38;
  localparam logic [7:0] CODE_KEYPAD = 8'h40;
  localparam logic [7:0] CODE_SERIAL = 8'h41;
  localparam logic [7:0] CODE_PRG_INVALID = 8'h43;
  localparam logic [7:0] CODE_PRG_NEST = 8'h44;
  localparam logic [7:0] CODE_PRG_INSTR = 8'h45;
  localparam logic [7:0] CODE_ENCODER = 8'h80;
  localparam logic [7:0] CODE_OVERSPEED = 8'h81;
  localparam logic [7:0] CODE_POSITION = 8'h83;
  localparam logic [3:0] CODE_USER_TENS = 4'h5;
  localparam logic [3:0] CODE_OPTION_TENS = 4'h6;

  // Limits and settings
  localparam logic [3:0] NEST_LIMIT = 4'h8;
  localparam logic [3:0] INDEX_MAX = 4'h9;
  localparam logic [1:0] COMM_ACT_TRIP = 2'h0;
  localparam logic [31:0] OVS_SCALE = 32'h64;
  localparam int HIST_DEPTH = 6;
  localparam int NFAULT = 20;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONF_WAIT = 8'h04;
  localparam logic [7:0] ADDR_REL_WAIT = 8'h08;
  localparam logic [7:0] ADDR_MAX_FREQ = 8'h0c;
  localparam logic [7:0] ADDR_OVS_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_POS_MIN = 8'h14;
  localparam logic [7:0] ADDR_POS_MAX = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_HIST0 = 8'h20;
  localparam logic [7:0] ADDR_HIST5 = 8'h34;

  // Control register fields and reset values
  localparam int CTRL_BRAKE_BIT = 0;
  localparam int CTRL_COMM_LSB = 1;
  localparam int CTRL_THERM_BIT = 3;
  localparam int CTRL_PRG_BIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [31:0] WAIT_RESET = 32'h0000_ffff;
  localparam logic [15:0] MAX_FREQ_RESET = 16'hffff;
  localparam logic [7:0] OVS_LEVEL_RESET = 8'h64;
  localparam logic [31:0] POS_MIN_RESET = 32'h8000_0000;
  localparam logic [31:0] POS_MAX_RESET = 32'h7fff_ffff;

  // Status register fields
  localparam int STAT_TRIP_BIT = 8;
  localparam int STAT_HOLD_BIT = 9;
  localparam int STAT_UV_BIT = 10;
  localparam int STAT_PWRCYC_BIT = 11;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sensor and terminal pins, all asynchronous to the clock
  typedef struct packed {
    logic keypad_reset;
    logic reset_terminal_input;
    logic undervoltage;
    logic brake_confirm;
    logic ground_fault;
    logic memory_fault;
    logic encoder_fault;
    logic prg_unexecutable;
    logic program_run_terminal;
    logic prg_corrupt;
    logic serial_timeout;
    logic keypad_link_lost;
    logic low_speed_overload;
    logic safe_stop;
    logic thermistor_hot;
    logic overcurrent;
    logic mains_unrecognised;
    logic cpu_link_lost;
    logic over_temp;
  } dtf_pins_s;

  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } dtf_axi_req_s;

  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dtf_axi_rsp_s;

endpackage

//--- sim/dtf_field_model.sv
// Field-side model: fault sensors, keypad key and reset terminal levels at the pins
`timescale 1ns/1ps

module dtf_field_model (
  // Clock
  input wire logic sys_clk_i,
  // Levels commanded by the bench
  input wire logic [18:0] cmd_i,
  // Pin levels towards the block
  output dtf_pkg::dtf_pins_s pins_o
);

  // Pins move just after an edge, like real contacts; the keypad key and the terminal are both reset paths
  always_ff @(posedge sys_clk_i) begin
    pins_o <= cmd_i;
  end

endmodule

//--- sim/tb.sv
// Self-checking bench of the drive trip fault manager
`timescale 1ns/1ps

module tb;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  dtf_pkg::dtf_axi_req_s req = '0;
  dtf_pkg::dtf_axi_rsp_s rsp;
  dtf_pkg::dtf_pins_s pins;
  logic [18:0] cmd = '0;
  logic brel = 1'b0;
  logic rreq = 1'b0;
  logic rok = 1'b0;
  logic [15:0] speed = '0;
  logic [31:0] pos = '0;
  logic [3:0] nest = '0;
  logic utrip = 1'b0;
  logic [3:0] uidx = '0;
  logic ofault = 1'b0;
  logic [3:0] oidx = '0;
  logic power_enable_o, tripped_o, undervolt_wait_o, reset_blocked_o;
  logic [7:0] trip_code_o;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  dtf_field_model i_dtf_field_model (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .pins_o(pins));

  dtf_trip_manager #(.RESET_HOLD_CYCLES(20)) i_dtf_trip_manager (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .pins_i(pins), .brake_release_i(brel), .release_current_req_i(rreq),
    .release_current_ok_i(rok), .speed_i(speed), .position_i(pos),
    .nest_depth_i(nest), .user_trip_i(utrip), .user_trip_index_i(uidx),
    .option_fault_i(ofault), .option_fault_index_i(oidx),
    .power_enable_o(power_enable_o), .tripped_o(tripped_o), .trip_code_o(trip_code_o),
    .undervolt_wait_o(undervolt_wait_o), .reset_blocked_o(reset_blocked_o));

  // Clock generation
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Verdict and end of run
  task automatic results();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Power cycle: clears every latched trip and returns each register to its reset value
  task automatic pwr();
    reset_i <= 1'b1; cmd <= '0; brel <= 1'b0; speed <= '0; pos <= '0;
    nest <= '0; utrip <= 1'b0; ofault <= 1'b0;
    rreq <= 1'b0;
    rok <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic wtrip();
    int n;
    n = 0;
    while (tripped_o !== 1'b1 && n < 60) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic press(input int b);
    cmd[b] <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    cmd[b] <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask

  // One fault source after a power cycle; thermistor marked connected
  task automatic hit(input logic [7:0] s, input logic [7:0] code);
    pwr();
    wr(dtf_pkg::ADDR_CTRL, 32'h8);
    case (s[7:4])
      4'h4: begin uidx <= s[3:0]; utrip <= 1'b1; end
      4'h5: begin oidx <= s[3:0]; ofault <= 1'b1; end
      4'h6: begin
        if (s[1:0] == 2'd0) nest <= 4'h9;
        if (s[1:0] == 2'd1) speed <= 16'hffff;
        if (s[1:0] == 2'd2) begin wr(dtf_pkg::ADDR_POS_MAX, 32'h0); pos <= 32'h1; end
        if (s[1:0] == 2'd3) begin
          wr(dtf_pkg::ADDR_CONF_WAIT, 32'h4); wr(dtf_pkg::ADDR_CTRL, 32'h9); brel <= 1'b1;
        end
      end
      4'h7: begin
        wr(dtf_pkg::ADDR_REL_WAIT, 32'h4);
        wr(dtf_pkg::ADDR_CTRL, 32'h9);
        rreq <= 1'b1;
      end
      default: cmd[s[4:0]] <= 1'b1;
    endcase
    wtrip();
    chk(trip_code_o, code);
    chk(power_enable_o, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(dtf_pkg::ADDR_OVS_LEVEL); chk(rd_d, 32'h64);
    rd(dtf_pkg::ADDR_POS_MIN); chk(rd_d, 32'h8000_0000);
    rd(8'h40); chk(rd_r, dtf_pkg::RESP_SLVERR);
    wr(dtf_pkg::ADDR_CTRL, 32'h1f); rd(dtf_pkg::ADDR_CTRL); chk(rd_d, 32'h1f);
    hit(8'd0, 8'h21);
    hit(8'd1, 8'h22);
    hit(8'd2, 8'h25);
    hit(8'd3, 8'h30);
    hit(8'd4, 8'h35);
    hit(8'h63, 8'h36);
    hit(8'd5, 8'h37);
    hit(8'd6, 8'h38);
    hit(8'd7, 8'h40);
    hit(8'd8, 8'h41);
    hit(8'd9, 8'h43);
    hit(8'd10, 8'h43);
    hit(8'h60, 8'h44);
    hit(8'd11, 8'h45);
    for (int k = 0; k < 10; k++) hit(8'h40 | 8'(k), {dtf_pkg::CODE_USER_TENS, 4'(k)});
    for (int k = 0; k < 10; k++) hit(8'h50 | 8'(k), {dtf_pkg::CODE_OPTION_TENS, 4'(k)});
    hit(8'd12, 8'h80);
    hit(8'h61, 8'h81);
    hit(8'h62, 8'h83);
    hit(8'd13, 8'h08);
    hit(8'd14, 8'h14);
    hit(8'h70, 8'h36);
    // Safe stop: early reset refused, keypad ignored, terminal clears
    hit(8'd5, 8'h37);
    cmd[5] <= 1'b0;
    @(posedge sys_clk_i);
    chk(reset_blocked_o, 1'b1);
    press(17); chk(tripped_o, 1'b1);
    repeat (25) @(posedge sys_clk_i);
    press(18); chk(tripped_o, 1'b1);
    press(17); chk(tripped_o, 1'b0);
    chk(power_enable_o, 1'b1);
    cmd[0] <= 1'b1; wtrip();
    rd(dtf_pkg::ADDR_HIST0); chk(rd_d[7:0], 8'h21);
    rd(dtf_pkg::ADDR_HIST0 + 8'h4); chk(rd_d[7:0], 8'h37);
    // Keypad key clears an ordinary trip once the hold-off has run out
    cmd[0] <= 1'b0;
    repeat (25) @(posedge sys_clk_i);
    chk(reset_blocked_o, 1'b0);
    press(18);
    chk(tripped_o, 1'b0);
    // Simultaneous faults, later fault ignored, driver trip needs power cycle
    pwr(); cmd <= 19'h9; wtrip(); chk(trip_code_o, 8'h30);
    cmd[5] <= 1'b1; repeat (6) @(posedge sys_clk_i); chk(trip_code_o, 8'h30);
    cmd <= '0; repeat (25) @(posedge sys_clk_i);
    press(17); chk(tripped_o, 1'b1);
    press(18);
    chk(tripped_o, 1'b1);
    // Undervoltage waits without a trip
    pwr(); cmd[16] <= 1'b1; repeat (6) @(posedge sys_clk_i);
    chk({undervolt_wait_o, power_enable_o, tripped_o}, 3'b100);
    // Sources disabled by setting or satisfied in time must not trip
    pwr();
    wr(dtf_pkg::ADDR_REL_WAIT, 32'h2);
    wr(dtf_pkg::ADDR_CONF_WAIT, 32'h4);
    wr(dtf_pkg::ADDR_CTRL, 32'h13);
    cmd <= 19'h08510;
    rreq <= 1'b1;
    rok <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    brel <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    chk(tripped_o, 1'b0);
    results();
  end

endmodule
